// ---- src/lcs_sequencer.sv ----
// Purpose: Serial command interpreter that stages presets and enters load modes.
// Assumes: rxd is synchronous to clk and idles high.
// Notes: No reply frames are sent; outcome shows on mode_start and cmd_reject.
`timescale 1ns/1ps
module lcs_sequencer
  import lcs_pkg::*;
#(
  parameter logic [15:0] BIT_CYC_4800 = 16'(BIT_CYC_4800_DEF),
  parameter logic [15:0] BIT_CYC_9600 = 16'(BIT_CYC_9600_DEF),
  parameter logic [15:0] BIT_CYC_19200 = 16'(BIT_CYC_19200_DEF),
  parameter logic [15:0] BIT_CYC_38400 = 16'(BIT_CYC_38400_DEF)
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic rxd,
  input wire logic local_cfg_we,
  input wire lcs_cfg_s local_cfg,
  output lcs_cfg_s comm_cfg,
  output logic remote_grant,
  output logic remote_enable,
  output logic [7:0] active_mode,
  output logic mode_start,
  output logic cmd_reject,
  output logic rx_error,
  output logic [NPARAM-1:0][63:0] param_applied
);

  function automatic logic [15:0] baud_cycles(input logic [1:0] sel);
    case (sel)
      BSEL_4800: baud_cycles = BIT_CYC_4800;
      BSEL_19200: baud_cycles = BIT_CYC_19200;
      BSEL_38400: baud_cycles = BIT_CYC_38400;
      default: baud_cycles = BIT_CYC_9600;
    endcase
  endfunction

  // Which staged parameters each mode command copies into the live set.
  function automatic logic [NPARAM-1:0] mode_mask(input logic [7:0] code);
    logic [NPARAM-1:0] m;
    m = '0;
    case (code)
      CMD_VLOAD: m[P_VOFF:P_VSET] = '1;
      CMD_PLOAD: m[P_POFF:P_PSET] = '1;
      CMD_RLOAD: m[P_ROFF:P_RSET] = '1;
      CMD_ICROSS: m[P_ICROSS:P_ISET] = '1;
      CMD_RCROSS, CMD_RCROSS_ALT: begin
        m[P_RSET] = 1'b1;
        m[P_RCROSS] = 1'b1;
      end
      CMD_BATT: begin
        m[P_ISET] = 1'b1;
        m[P_BATEND] = 1'b1;
      end
      CMD_DYN: m[P_WAVE:P_DYNA] = '1;
      CMD_SYS: m[P_PLIM:P_ILIM] = '1;
      default: m = '0;
    endcase
    return m;
  endfunction

  lcs_cfg_s cfg_q;
  lcs_rx_e rx_st_q;
  logic [15:0] rx_cnt_q, bit_cyc;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_sh_q, mode_q, cmd_code;
  logic [19:0] gap_q, gap_lim;
  lcs_ps_e ps_q;
  lcs_frame_s fr_q;
  logic [3:0] need_q, n_q;
  logic [63:0] staged_q [NPARAM];
  logic [NPARAM-1:0][63:0] applied_q;
  logic [NPARAM-1:0] cmd_mask;
  logic rx_par_q, rx_perr_q, rx_byte_q, rx_err_q, gap_hit, fr_valid_q, grant_q, stage_remote_q;
  logic remote_en_q, mode_start_q, cmd_reject_q, is_coil, is_preset, cmd_wr, cmd_fire;

  assign bit_cyc = baud_cycles(cfg_q.baud);
  assign gap_lim = 20'(bit_cyc * GAP_BITS);
  assign gap_hit = (gap_q == gap_lim);

  // Receiver samples mid-bit; a bad parity or a low stop bit drops the byte.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= '0;
      rx_bit_q <= '0;
      rx_sh_q <= '0;
      rx_par_q <= 1'b0;
      rx_perr_q <= 1'b0;
      rx_byte_q <= 1'b0;
      rx_err_q <= 1'b0;
    end else begin
      rx_byte_q <= 1'b0;
      rx_err_q <= 1'b0;
      case (rx_st_q)
        RX_IDLE: begin
          if (!rxd) begin
            rx_st_q <= RX_START;
            rx_cnt_q <= bit_cyc >> 1;
          end
        end
        RX_START: begin
          if (rx_cnt_q != 16'h0000) begin
            rx_cnt_q <= rx_cnt_q - 16'h0001;
          end else if (!rxd) begin
            rx_st_q <= RX_DATA;
            rx_cnt_q <= bit_cyc - 16'h0001;
            rx_bit_q <= '0;
            rx_par_q <= 1'b0;
            rx_perr_q <= 1'b0;
          end else begin
            rx_st_q <= RX_IDLE;
          end
        end
        RX_DATA: begin
          if (rx_cnt_q != 16'h0000) begin
            rx_cnt_q <= rx_cnt_q - 16'h0001;
          end else begin
            rx_sh_q <= {rxd, rx_sh_q[7:1]};
            rx_par_q <= rx_par_q ^ rxd;
            rx_bit_q <= rx_bit_q + 3'h1;
            rx_cnt_q <= bit_cyc - 16'h0001;
            if (rx_bit_q == 3'h7) begin
              rx_st_q <= (cfg_q.parity == PAR_NONE) ? RX_STOP : RX_PAR;
            end
          end
        end
        RX_PAR: begin
          if (rx_cnt_q != 16'h0000) begin
            rx_cnt_q <= rx_cnt_q - 16'h0001;
          end else begin
            rx_perr_q <= (rx_par_q ^ rxd) != (cfg_q.parity == PAR_ODD);
            rx_cnt_q <= bit_cyc - 16'h0001;
            rx_st_q <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_cnt_q != 16'h0000) begin
            rx_cnt_q <= rx_cnt_q - 16'h0001;
          end else begin
            rx_byte_q <= rxd && !rx_perr_q;
            rx_err_q <= !rxd || rx_perr_q;
            rx_st_q <= RX_IDLE;
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // A quiet line of forty bit times resynchronises the frame parser.
  always_ff @(posedge clk) begin
    if (sys_rst || rx_st_q != RX_IDLE || rx_byte_q) begin
      gap_q <= '0;
    end else if (!gap_hit) begin
      gap_q <= gap_q + 20'h00001;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ps_q <= PS_ADDR;
      fr_q <= '0;
      fr_valid_q <= 1'b0;
      need_q <= '0;
      n_q <= '0;
    end else begin
      fr_valid_q <= 1'b0;
      if (rx_err_q) begin
        ps_q <= PS_SKIP;
      end else if (rx_byte_q) begin
        case (ps_q)
          PS_ADDR: ps_q <= (rx_sh_q == cfg_q.addr) ? PS_FUNC : PS_SKIP;
          PS_FUNC: begin
            fr_q.func <= rx_sh_q;
            need_q <= (rx_sh_q == FC_COIL) ? LEN_COIL : LEN_PRESET;
            ps_q <= (rx_sh_q == FC_COIL || rx_sh_q == FC_PRESET) ? PS_INDEX : PS_SKIP;
          end
          PS_INDEX: begin
            fr_q.index <= rx_sh_q;
            fr_q.data <= '0;
            n_q <= '0;
            ps_q <= PS_DATA;
          end
          PS_DATA: begin
            fr_q.data <= {fr_q.data[55:0], rx_sh_q};
            n_q <= n_q + 4'h1;
            if (n_q == need_q - 4'h1) begin
              fr_valid_q <= 1'b1;
              ps_q <= PS_ADDR;
            end
          end
          default: ps_q <= PS_SKIP;
        endcase
      end else if (gap_hit) begin
        ps_q <= PS_ADDR;
      end
    end
  end

  assign is_coil = fr_valid_q && fr_q.func == FC_COIL;
  assign is_preset = fr_valid_q && fr_q.func == FC_PRESET;
  assign cmd_code = fr_q.data[7:0];
  assign cmd_mask = mode_mask(cmd_code);
  assign cmd_wr = is_preset && fr_q.index == IDX_CMD;
  assign cmd_fire = cmd_wr && grant_q && fr_q.data[63:8] == '0
                    && cmd_mask != '0;

  // Local settings win when both sources write in the same cycle.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_q <= CFG_RST;
    end else if (local_cfg_we) begin
      cfg_q <= local_cfg;
    end else if (is_preset && fr_q.index == IDX_COMM && fr_q.data[3:2] != 2'h3) begin
      cfg_q <= '{addr: fr_q.data[15:8], parity: fr_q.data[3:2], baud: fr_q.data[1:0]};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      grant_q <= 1'b0;
      stage_remote_q <= 1'b0;
    end else if (is_coil && (fr_q.data[15:0] == COIL_ON || fr_q.data[15:0] == COIL_OFF)) begin
      if (fr_q.index == COIL_GRANT) begin
        grant_q <= fr_q.data[15:0] == COIL_ON;
      end
      if (fr_q.index == COIL_REMOTE) begin
        stage_remote_q <= fr_q.data[15:0] == COIL_ON;
      end
    end
  end

  // Out-of-range waveform selectors are dropped so the live value stays legal.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      staged_q <= '{default: '0};
    end else if (is_preset && fr_q.index < 8'(NPARAM)
                 && !(fr_q.index == 8'(P_WAVE) && fr_q.data > WAVE_MAX)) begin
      staged_q[fr_q.index[4:0]] <= fr_q.data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      applied_q <= '0;
      remote_en_q <= 1'b0;
    end else if (cmd_fire) begin
      for (int i = 0; i < NPARAM; i++) begin
        if (cmd_mask[i]) begin
          applied_q[i] <= staged_q[i];
        end
      end
      remote_en_q <= (cmd_code == CMD_SYS) ? stage_remote_q : remote_en_q;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_q <= MODE_RST;
      mode_start_q <= 1'b0;
      cmd_reject_q <= 1'b0;
    end else begin
      mode_start_q <= cmd_fire;
      cmd_reject_q <= cmd_wr && !cmd_fire;
      if (cmd_fire) begin
        mode_q <= cmd_code;
      end
    end
  end

  assign comm_cfg = cfg_q;
  assign remote_grant = grant_q;
  assign remote_enable = remote_en_q;
  assign active_mode = mode_q;
  assign mode_start = mode_start_q;
  assign cmd_reject = cmd_reject_q;
  assign rx_error = rx_err_q;
  assign param_applied = applied_q;

  AST_VLOAD: assert property (@(posedge clk) disable iff (sys_rst)
    cmd_fire && cmd_code == CMD_VLOAD |=> active_mode == CMD_VLOAD
      && param_applied[P_VOFF] == $past(staged_q[P_VOFF]))
    else $error("voltage load mode not entered");
  AST_PLOAD: assert property (@(posedge clk) disable iff (sys_rst)
    cmd_fire && cmd_code == CMD_PLOAD |=> mode_start && active_mode == CMD_PLOAD
      && param_applied[P_PON] == $past(staged_q[P_PON]))
    else $error("power load mode not entered");
  AST_RLOAD: assert property (@(posedge clk) disable iff (sys_rst)
    cmd_fire && cmd_code == CMD_RLOAD |=> param_applied[P_RSET] == $past(staged_q[P_RSET])
      && param_applied[P_ICROSS] == $past(param_applied[P_ICROSS]))
    else $error("resistance load mode applied wrong set");
  AST_ICROSS: assert property (@(posedge clk) disable iff (sys_rst)
    cmd_fire && cmd_code == CMD_ICROSS |=> active_mode == CMD_ICROSS
      && param_applied[P_ICROSS] == $past(staged_q[P_ICROSS]))
    else $error("current crossover mode not entered");
  AST_RCROSS: assert property (@(posedge clk) disable iff (sys_rst)
    cmd_wr && grant_q && fr_q.data == 64'(CMD_RCROSS) |=> mode_start ##1 !mode_start)
    else $error("resistance crossover code not accepted");
  AST_BATT: assert property (@(posedge clk) disable iff (sys_rst)
    cmd_fire && cmd_code == CMD_BATT |=> param_applied[P_BATEND] == $past(staged_q[P_BATEND]))
    else $error("battery end voltage not applied");
  AST_DYN: assert property (@(posedge clk) disable iff (sys_rst)
    param_applied[P_WAVE] <= WAVE_MAX)
    else $error("waveform selector out of range");
  AST_SYS: assert property (@(posedge clk) disable iff (sys_rst)
    cmd_fire && cmd_code == CMD_SYS |=> remote_enable == $past(stage_remote_q)
      && param_applied[P_PLIM] == $past(staged_q[P_PLIM]))
    else $error("system parameters not applied");
  AST_BAUD: assert property (@(posedge clk) disable iff (sys_rst)
    $past(sys_rst) && !local_cfg_we |-> comm_cfg.baud == BSEL_9600)
    else $error("baud not default after reset");
  AST_STOP: assert property (@(posedge clk) disable iff (sys_rst)
    rx_st_q == RX_STOP && rx_cnt_q == 16'h0000 && !rxd |=> rx_error && !rx_byte_q)
    else $error("framing error not flagged");
  AST_LOCAL: assert property (@(posedge clk) disable iff (sys_rst)
    local_cfg_we |=> comm_cfg == $past(local_cfg))
    else $error("local settings not taken");
  AST_GRANT: assert property (@(posedge clk) disable iff (sys_rst)
    mode_start |-> $past(grant_q) && $past(cmd_wr))
    else $error("mode started without remote grant");
  AST_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    !cmd_fire |=> $stable(param_applied))
    else $error("live parameters changed without command");
endmodule

// ---- src/lcs_pkg.sv ----
// Purpose: Shared constants and types for the load command sequencer.
// Assumes: 50 MHz clock, byte-oriented serial frames from the host.
// Notes: Frame indices and the comm settings layout are local choices.
package lcs_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int BAUD_4800 = 4800;
  localparam int BAUD_9600 = 9600;
  localparam int BAUD_19200 = 19200;
  localparam int BAUD_38400 = 38400;
  localparam int BIT_CYC_4800_DEF = (CLK_HZ + BAUD_4800 / 2) / BAUD_4800;
  localparam int BIT_CYC_9600_DEF = (CLK_HZ + BAUD_9600 / 2) / BAUD_9600;
  localparam int BIT_CYC_19200_DEF = (CLK_HZ + BAUD_19200 / 2) / BAUD_19200;
  localparam int BIT_CYC_38400_DEF = (CLK_HZ + BAUD_38400 / 2) / BAUD_38400;
  localparam int GAP_BITS = 40;
  localparam logic [1:0] BSEL_4800 = 2'h0;
  localparam logic [1:0] BSEL_9600 = 2'h1;
  localparam logic [1:0] BSEL_19200 = 2'h2;
  localparam logic [1:0] BSEL_38400 = 2'h3;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [7:0] ADDR_RST = 8'h01;
  localparam logic [7:0] FC_COIL = 8'h05;
  localparam logic [7:0] FC_PRESET = 8'h10;
  localparam logic [3:0] LEN_COIL = 4'h2;
  localparam logic [3:0] LEN_PRESET = 4'h8;
  localparam logic [15:0] COIL_ON = 16'hFF00;
  localparam logic [15:0] COIL_OFF = 16'h0000;
  localparam logic [7:0] COIL_GRANT = 8'h00;
  localparam logic [7:0] COIL_REMOTE = 8'h01;
  localparam logic [7:0] IDX_CMD = 8'h20;
  localparam logic [7:0] IDX_COMM = 8'h21;
  localparam int NPARAM = 23;
  localparam int P_VSET = 0, P_VON = 1, P_VOFF = 2, P_PSET = 3, P_PON = 4, P_POFF = 5;
  localparam int P_RSET = 6, P_RON = 7, P_ROFF = 8, P_ISET = 9, P_ICROSS = 10;
  localparam int P_RCROSS = 11, P_BATEND = 12, P_DYNA = 13, P_DYNB = 14, P_WIDA = 15;
  localparam int P_WIDB = 16, P_RISE = 17, P_FALL = 18, P_WAVE = 19;
  localparam int P_ILIM = 20, P_VLIM = 21, P_PLIM = 22;
  localparam logic [63:0] WAVE_MAX = 64'h2;
  localparam logic [7:0] CMD_DYN = 8'h19;
  localparam logic [7:0] CMD_VLOAD = 8'h1F;
  localparam logic [7:0] CMD_PLOAD = 8'h20;
  localparam logic [7:0] CMD_RLOAD = 8'h21;
  localparam logic [7:0] CMD_ICROSS = 8'h22;
  localparam logic [7:0] CMD_RCROSS = 8'h23;
  localparam logic [7:0] CMD_RCROSS_ALT = 8'h24;
  localparam logic [7:0] CMD_BATT = 8'h26;
  localparam logic [7:0] CMD_SYS = 8'h29;
  localparam logic [7:0] MODE_RST = 8'h00;
  typedef struct packed {
    logic [7:0] addr;
    logic [1:0] parity;
    logic [1:0] baud;
  } lcs_cfg_s;
  typedef struct packed {
    logic [7:0] func;
    logic [7:0] index;
    logic [63:0] data;
  } lcs_frame_s;
  localparam lcs_cfg_s CFG_RST = '{addr: ADDR_RST, parity: PAR_NONE, baud: BSEL_9600};
  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001, RX_START = 5'b00010, RX_DATA = 5'b00100,
    RX_PAR = 5'b01000, RX_STOP = 5'b10000
  } lcs_rx_e;
  typedef enum logic [4:0] {
    PS_ADDR = 5'b00001, PS_FUNC = 5'b00010, PS_INDEX = 5'b00100,
    PS_DATA = 5'b01000, PS_SKIP = 5'b10000
  } lcs_ps_e;
endpackage

// ---- tb/lcs_host_model.sv ----
// Purpose: Host-side serial transmitter that sends command frames to the sequencer.
// Assumes: The caller picks the bit time and parity that match the device settings.
// Notes: The line rests high between characters, as an idle asynchronous line does.
`timescale 1ns/1ps
module lcs_host_model
  import lcs_pkg::*;
(
  input wire logic clk,
  output logic rxd
);
  initial rxd = 1'b1;

  task automatic put_bit(input logic v, input int cyc);
    repeat (cyc) begin
      @(posedge clk);
      rxd <= v;
    end
  endtask

  // A bad flag spoils the first character only, its parity or, without parity, its stop bit.
  task automatic send_frame(input logic [7:0] fb [11], input int nb, input logic [1:0] par,
                            input int cyc, input logic bad);
    logic p;
    for (int k = 0; k < nb; k++) begin
      put_bit(1'b0, cyc);
      for (int i = 0; i < 8; i++) put_bit(fb[k][i], cyc);
      p = (^fb[k]) ^ (par == PAR_ODD) ^ (bad && k == 0);
      if (par != PAR_NONE) put_bit(p, cyc);
      put_bit(!(bad && k == 0 && par == PAR_NONE), cyc);
    end
  endtask
endmodule

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench for the load command sequencer.
// Assumes: Shortened bit times; host frames come from lcs_host_model.
// Notes: Expected parameter sets are kept in a shadow copy inside the bench.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module testbench
  import lcs_pkg::*;
;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic rxd, remote_grant, remote_enable, mode_start, cmd_reject, rx_error;
  logic local_cfg_we = 1'b0;
  lcs_cfg_s local_cfg = CFG_RST;
  lcs_cfg_s comm_cfg;
  logic [7:0] active_mode, act_x;
  logic [7:0] addr_x = 8'h01;
  logic [NPARAM-1:0][63:0] param_applied;
  logic [63:0] stg [NPARAM];
  logic [63:0] app [NPARAM];
  logic rem_stg = 1'b0;
  logic rem_x = 1'b0;
  logic [1:0] par_x = 2'h0;
  int cyc_x = 8, n_errors = 0, comparisons = 0, n_st = 0, n_rj = 0, n_rx = 0, cycles = 0;
  logic [31:0] seed = 32'hA32B9550;
  logic [7:0] codes [9] = '{8'h1F, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h26, 8'h19, 8'h29};

  always #10 clk = ~clk;

  lcs_sequencer #(.BIT_CYC_4800(16'h000C), .BIT_CYC_9600(16'h0008),
    .BIT_CYC_19200(16'h0006), .BIT_CYC_38400(16'h0004)) dut (.clk(clk), .sys_rst(sys_rst),
    .rxd(rxd), .local_cfg_we(local_cfg_we), .local_cfg(local_cfg), .comm_cfg(comm_cfg),
    .remote_grant(remote_grant), .remote_enable(remote_enable), .active_mode(active_mode),
    .mode_start(mode_start), .cmd_reject(cmd_reject), .rx_error(rx_error),
    .param_applied(param_applied));
  lcs_host_model host (.clk(clk), .rxd(rxd));

  task automatic complete_run();
    $display("Errors %0d, comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (mode_start === 1'b1) n_st++;
    if (cmd_reject === 1'b1) n_rj++;
    if (rx_error === 1'b1) n_rx++;
    if (cycles == 90000) begin
      n_errors++;
      complete_run();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic int cyc_of(input int b);
    return (b == 0) ? 12 : (b == 1) ? 8 : (b == 2) ? 6 : 4;
  endfunction

  function automatic logic [NPARAM-1:0] mask(input logic [7:0] c);
    case (c)
      8'h1F: return 23'h7;
      8'h20: return 23'h38;
      8'h21: return 23'h1C0;
      8'h22: return 23'h600;
      8'h23, 8'h24: return 23'h840;
      8'h26: return 23'h1200;
      8'h19: return 23'hFE000;
      8'h29: return 23'h700000;
      default: return 23'h0;
    endcase
  endfunction

  task automatic frame(input logic [7:0] fn, idx, input logic [63:0] v, input int nb,
                       input logic bad);
    logic [7:0] fb [11];
    fb = '{default: 8'h00};
    fb[0] = addr_x;
    fb[1] = fn;
    fb[2] = idx;
    for (int i = 0; i < nb; i++) fb[3 + i] = v[8 * (nb - 1 - i) +: 8];
    host.send_frame(fb, 3 + nb, par_x, cyc_x, bad);
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic preset(input logic [7:0] idx, input logic [63:0] v);
    frame(FC_PRESET, idx, v, 8, 1'b0);
    if (idx < NPARAM && !(idx == 8'h13 && v > 64'h2)) stg[idx] = v;
  endtask

  task automatic coil(input logic [7:0] idx, input logic on);
    frame(FC_COIL, idx, on ? 64'hFF00 : 64'h0, 2, 1'b0);
    if (idx == 8'h01) rem_stg = on;
  endtask

  task automatic command(input logic [63:0] v, input int es, er);
    int s0;
    int r0;
    logic [NPARAM-1:0] m;
    s0 = n_st;
    r0 = n_rj;
    m = mask(v[7:0]);
    frame(FC_PRESET, IDX_CMD, v, 8, 1'b0);
    `CHK(n_st - s0, es)
    `CHK(n_rj - r0, er)
    if (es == 1) begin
      act_x = v[7:0];
      if (v[7:0] == 8'h29) rem_x = rem_stg;
      for (int i = 0; i < NPARAM; i++) if (m[i]) app[i] = stg[i];
    end
    `CHK(active_mode, act_x)
    `CHK(remote_enable, rem_x)
    for (int i = 0; i < NPARAM; i++) `CHK(param_applied[i], app[i])
  endtask

  initial begin
    int rx0;
    int st0;
    for (int i = 0; i < NPARAM; i++) begin
      stg[i] = 64'h0;
      app[i] = 64'h0;
    end
    act_x = 8'h00;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(comm_cfg, 12'h011)
    `CHK(remote_grant, 1'b0)
    command(64'h1F, 0, 1);
    coil(8'h00, 1'b1);
    `CHK(remote_grant, 1'b1)
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < NPARAM; i++)
        if (r == 0 || (rnd() & 32'h1) != 32'h0)
          preset(8'(i), (i == 19) ? 64'(rnd() % 3) : {rnd(), rnd()});
      for (int k = 0; k < 9; k++) command({56'h0, codes[k]}, 1, 0);
    end
    preset(8'h13, 64'h3);
    command(64'h19, 1, 0);
    command(64'h01, 0, 1);
    command(64'h11F, 0, 1);
    coil(8'h01, 1'b1);
    command(64'h29, 1, 0);
    coil(8'h01, 1'b0);
    `CHK(remote_enable, 1'b1)
    command(64'h29, 1, 0);
    for (int b = 0; b < 4; b++) begin
      @(posedge clk);
      local_cfg <= '{addr: 8'h01, parity: (b == 3) ? 2'h1 : 2'(b), baud: 2'(b)};
      local_cfg_we <= 1'b1;
      @(posedge clk);
      local_cfg_we <= 1'b0;
      @(posedge clk);
      #1;
      `CHK(comm_cfg, local_cfg)
      par_x = local_cfg.parity;
      cyc_x = cyc_of(b);
      command({56'h0, codes[rnd() % 9]}, 1, 0);
    end
    rx0 = n_rx;
    st0 = n_st;
    frame(FC_PRESET, IDX_CMD, 64'h1F, 8, 1'b1);
    `CHK(n_rx - rx0, 1)
    `CHK(n_st - st0, 0)
    // The parser only resynchronises after a quiet line, so wait out the gap.
    repeat (41 * cyc_x) @(posedge clk);
    preset(IDX_COMM, 64'h0502);
    `CHK(comm_cfg, 12'h052)
    par_x = 2'h0;
    cyc_x = 6;
    rx0 = n_rx;
    frame(FC_PRESET, IDX_CMD, 64'h1F, 8, 1'b1);
    `CHK(n_rx - rx0, 1)
    command(64'h20, 0, 0);
    repeat (41 * cyc_x) @(posedge clk);
    addr_x = 8'h05;
    command(64'h20, 1, 0);
    coil(8'h00, 1'b0);
    `CHK(remote_grant, 1'b0)
    command(64'h21, 0, 1);
    complete_run();
  end
endmodule
